// [hdl/bcx_pkg.sv]
// Constants and types for the single-operand execution block
// Notes on behaviour
// RQ1: Complement to working register: inverse of byte, memory kept, only zero flag.
// RQ2: Decimal adjust adds 6 to low nibble if above 9 or half carry.
// RQ3: Decimal adjust adds 6 to high nibble if above 9 or carry.
// RQ4: Decimal adjust stores working register plus 00, 06, 60 or 66 to memory.
// RQ5: Decimal adjust touches only carry, set when the BCD sum passes 100.
// RQ6: Memory minus one writes the byte minus one back, updates zero.
// RQ7: Minus one to working register keeps memory, loads result, updates zero.
// RQ8: Memory plus one writes the byte plus one back, updates zero.
// RQ9: Plus one to working register loads result and keeps memory.
// RQ10: Power-down stops execution and clock, keeping memory and registers.
// RQ11: Power-down clears the watchdog counter and its prescaler.
// RQ12: Power-down sets power-down flag, clears timeout flag, nothing else.
// RQ13: Zero flag set when the 8-bit result is zero, else cleared.
package bcx_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int MEM_DEPTH = 128;

    // Operation codes from the decoder
    localparam logic [2:0] OP_COMPLEMENT_TO_WREG = 3'h0;
    localparam logic [2:0] OP_DECIMAL_ADJUST     = 3'h1;
    localparam logic [2:0] OP_MINUS_ONE          = 3'h2;
    localparam logic [2:0] OP_MINUS_ONE_TO_WREG  = 3'h3;
    localparam logic [2:0] OP_PLUS_ONE           = 3'h4;
    localparam logic [2:0] OP_PLUS_ONE_TO_WREG   = 3'h5;
    localparam logic [2:0] OP_POWER_DOWN         = 3'h6;

    // Decimal adjust figures
    localparam logic [3:0] NIBBLE_MAX = 4'h9;
    localparam logic [3:0] NIBBLE_FIX = 4'h6;

    // Reset values
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic       ZERO_RST = 1'b0;
    localparam logic       CARRY_RST = 1'b0;
    localparam logic       HCARRY_RST = 1'b0;
    localparam logic       PDF_RST = 1'b0;
    localparam logic       TOF_RST = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_WB   = 2'b10
    } bcx_state_e;
endpackage

// [hdl/bcx_mem.sv]
// Data memory with registered read data
`timescale 1ns/1ps
module bcx_mem #(
    parameter int DW    = 8,
    parameter int AW    = 7,
    parameter int DEPTH = 128
) (
    // Clock
    input  wire logic          i_clk_sys,
    // Read port
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata,
    // Write port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata
);
    generate
        if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_chk
            $error("bcx_mem depth does not fit address width");
        end
    endgenerate

    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// [hdl/bcx_daa.sv]
// Decimal adjust of the working register value
`timescale 1ns/1ps
module bcx_daa (
    // Operand and flags
    input  wire logic [7:0] i_value,
    input  wire logic       i_carry,
    input  wire logic       i_hcarry,
    // Result
    output logic      [7:0] o_result,
    output logic            o_carry
);
    logic lo_fix;
    logic hi_fix;
    logic [8:0] sum;

    always_comb begin
        // RQ2: low nibble test
        lo_fix = (i_value[3:0] > bcx_pkg::NIBBLE_MAX) || i_hcarry;
        // RQ3: high nibble test
        hi_fix = (i_value[7:4] > bcx_pkg::NIBBLE_MAX) || i_carry;
        // RQ4: add 00, 06, 60 or 66
        sum = {1'b0, i_value}
            + {1'b0, (hi_fix ? bcx_pkg::NIBBLE_FIX : 4'h0),
                     (lo_fix ? bcx_pkg::NIBBLE_FIX : 4'h0)};
        o_result = sum[7:0];
        // RQ5: carry kept or set on decimal overflow
        o_carry = i_carry | hi_fix | sum[8];
    end
endmodule

// [hdl/bcx_core.sv]
// Single-operand execution block: adjust, inc/dec, complement, power-down
`timescale 1ns/1ps
module bcx_core #(
    parameter int AW    = bcx_pkg::ADDR_W,
    parameter int DEPTH = bcx_pkg::MEM_DEPTH
) (
    // Clock and reset
    input  wire logic          i_clk_sys,
    input  wire logic          i_srst,
    // Operation request
    input  wire logic          i_op_valid,
    input  wire logic [2:0]    i_op_code,
    input  wire logic [AW-1:0] i_addr,
    // Direct memory load
    input  wire logic          i_mem_wr,
    input  wire logic [7:0]    i_mem_wdata,
    // Working register and flag load
    input  wire logic          i_wreg_load,
    input  wire logic [7:0]    i_wreg_data,
    input  wire logic          i_flag_load,
    input  wire logic          i_flag_zero,
    input  wire logic          i_flag_carry,
    input  wire logic          i_flag_hcarry,
    // Watchdog and wake
    input  wire logic          i_wdt_timeout,
    input  wire logic          i_wake,
    // Status
    output logic               o_busy,
    output logic               o_done,
    output logic [7:0]         o_working_register,
    output logic               o_zero_flag,
    output logic               o_carry_flag,
    output logic               o_half_carry_flag,
    output logic               o_power_down_flag,
    output logic               o_watchdog_timeout_flag,
    output logic               o_watchdog_counter_clr,
    output logic               o_clock_off
);
    generate
        if (AW < 1 || DEPTH > (1 << AW)) begin : g_chk
            $error("bcx_core address width too small for depth");
        end
    endgenerate

    typedef struct packed {
        bcx_pkg::bcx_state_e st;
        logic [2:0]          op;
        logic [AW-1:0]       addr;
        logic [7:0]          wreg;
        logic                zf;
        logic                cf;
        logic                acf;
        logic                power_down_flag;
        logic                tof;
        logic                wdt_clr;
        logic                clk_off;
        logic                busy;
        logic                done;
        logic                we;
        logic [AW-1:0]       waddr;
        logic [7:0]          wdata;
    } bcx_core_s;

    bcx_core_s s_q;
    bcx_core_s s_d;

    logic [7:0] mem_rdata;
    logic [7:0] daa_res;
    logic       daa_carry;

    bcx_mem #(
        .DW    (8),
        .AW    (AW),
        .DEPTH (DEPTH)
    ) u_mem (
        .i_clk_sys (i_clk_sys),
        .i_raddr   (i_addr),
        .o_rdata   (mem_rdata),
        .i_we      (s_q.we),
        .i_waddr   (s_q.waddr),
        .i_wdata   (s_q.wdata)
    );

    bcx_daa u_daa (
        .i_value  (s_q.wreg),
        .i_carry  (s_q.cf),
        .i_hcarry (s_q.acf),
        .o_result (daa_res),
        .o_carry  (daa_carry)
    );

    always_comb begin
        logic [7:0] res;
        res = 8'h00;
        s_d = s_q;
        s_d.we = 1'b0;
        s_d.wdt_clr = 1'b0;
        s_d.done = 1'b0;
        // Watchdog expiry raises the timeout flag
        if (i_wdt_timeout) begin
            s_d.tof = 1'b1;
        end
        // RQ10: wake leaves power-down, state retained
        if (s_q.clk_off && i_wake) begin
            s_d.clk_off = 1'b0;
        end
        case (s_q.st)
            bcx_pkg::ST_IDLE: begin
                // RQ10: registers kept while halted
                if (i_wreg_load && !s_q.clk_off) begin
                    s_d.wreg = i_wreg_data;
                end
                if (i_flag_load && !s_q.clk_off) begin
                    s_d.zf = i_flag_zero;
                    s_d.cf = i_flag_carry;
                    s_d.acf = i_flag_hcarry;
                end
                // RQ10: no execution while clock is off
                if (i_op_valid && !s_q.clk_off) begin
                    if (i_op_code == bcx_pkg::OP_POWER_DOWN) begin
                        // RQ10: stop execution, gate clock
                        s_d.clk_off = 1'b1;
                        // RQ11: clear watchdog and prescaler
                        s_d.wdt_clr = 1'b1;
                        // RQ12: set power-down, clear timeout
                        s_d.power_down_flag = 1'b1;
                        s_d.tof = 1'b0;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.st = bcx_pkg::ST_EXEC;
                        s_d.op = i_op_code;
                        s_d.addr = i_addr;
                        s_d.busy = 1'b1;
                    end
                end else if (i_mem_wr && !s_q.clk_off) begin
                    s_d.we = 1'b1;
                    s_d.waddr = i_addr;
                    s_d.wdata = i_mem_wdata;
                end
            end
            bcx_pkg::ST_EXEC: begin
                s_d.st = bcx_pkg::ST_WB;
                s_d.waddr = s_q.addr;
                case (s_q.op)
                    bcx_pkg::OP_COMPLEMENT_TO_WREG: begin
                        // RQ1: inverse into working register
                        res = ~mem_rdata;
                        s_d.wreg = res;
                        // RQ13: zero flag from result
                        s_d.zf = (res == 8'h00);
                    end
                    bcx_pkg::OP_DECIMAL_ADJUST: begin
                        // RQ4: adjusted value to memory
                        s_d.we = 1'b1;
                        s_d.wdata = daa_res;
                        // RQ5: only carry changes
                        s_d.cf = daa_carry;
                    end
                    bcx_pkg::OP_MINUS_ONE: begin
                        // RQ6: decrement written back
                        res = mem_rdata - 8'h01;
                        s_d.we = 1'b1;
                        s_d.wdata = res;
                        // RQ13: zero flag from result
                        s_d.zf = (res == 8'h00);
                    end
                    bcx_pkg::OP_MINUS_ONE_TO_WREG: begin
                        // RQ7: decrement into working register
                        res = mem_rdata - 8'h01;
                        s_d.wreg = res;
                        // RQ13: zero flag from result
                        s_d.zf = (res == 8'h00);
                    end
                    bcx_pkg::OP_PLUS_ONE: begin
                        // RQ8: increment written back
                        res = mem_rdata + 8'h01;
                        s_d.we = 1'b1;
                        s_d.wdata = res;
                        // RQ13: zero flag from result
                        s_d.zf = (res == 8'h00);
                    end
                    bcx_pkg::OP_PLUS_ONE_TO_WREG: begin
                        // RQ9: increment into working register
                        res = mem_rdata + 8'h01;
                        s_d.wreg = res;
                        // RQ13: zero flag from result
                        s_d.zf = (res == 8'h00);
                    end
                    default: begin
                        res = 8'h00;
                    end
                endcase
            end
            bcx_pkg::ST_WB: begin
                s_d.st = bcx_pkg::ST_IDLE;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            default: begin
                s_d.st = bcx_pkg::ST_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            s_q <= '0;
            s_q.st <= bcx_pkg::ST_IDLE;
            s_q.wreg <= bcx_pkg::WREG_RST;
            s_q.zf <= bcx_pkg::ZERO_RST;
            s_q.cf <= bcx_pkg::CARRY_RST;
            s_q.acf <= bcx_pkg::HCARRY_RST;
            s_q.power_down_flag <= bcx_pkg::PDF_RST;
            s_q.tof <= bcx_pkg::TOF_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        o_busy = s_q.busy;
        o_done = s_q.done;
        o_working_register = s_q.wreg;
        o_zero_flag = s_q.zf;
        o_carry_flag = s_q.cf;
        o_half_carry_flag = s_q.acf;
        o_power_down_flag = s_q.power_down_flag;
        o_watchdog_timeout_flag = s_q.tof;
        o_watchdog_counter_clr = s_q.wdt_clr;
        o_clock_off = s_q.clk_off;
    end
endmodule

// [tb/bcx_core_properties.sv]
// Port-level properties of the single-operand execution block
`timescale 1ns/1ps
module bcx_core_properties #(
    parameter int AW = 7
) (
    input wire logic          i_clk_sys,
    input wire logic          i_srst,
    input wire logic          i_op_valid,
    input wire logic [2:0]    i_op_code,
    input wire logic [AW-1:0] i_addr,
    input wire logic          i_mem_wr,
    input wire logic [7:0]    i_mem_wdata,
    input wire logic          i_wreg_load,
    input wire logic [7:0]    i_wreg_data,
    input wire logic          i_flag_load,
    input wire logic          i_flag_zero,
    input wire logic          i_flag_carry,
    input wire logic          i_flag_hcarry,
    input wire logic          i_wdt_timeout,
    input wire logic          i_wake,
    input wire logic          o_busy,
    input wire logic          o_done,
    input wire logic [7:0]    o_working_register,
    input wire logic          o_zero_flag,
    input wire logic          o_carry_flag,
    input wire logic          o_half_carry_flag,
    input wire logic          o_power_down_flag,
    input wire logic          o_watchdog_timeout_flag,
    input wire logic          o_watchdog_counter_clr,
    input wire logic          o_clock_off
);
    logic take;
    logic take_pd;
    assign take = i_op_valid && !o_busy && !o_clock_off;
    assign take_pd = take && i_op_code == 3'h6;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);
    sequence s_finish;
        o_busy && !o_done ##1 !o_busy && o_done;
    endsequence
    property p_op_timing;
        take && i_op_code <= 3'h5 |=> o_busy && !o_done ##1 s_finish;
    endproperty
    a_op_timing: assert property (p_op_timing)
        else $error("operation timing wrong");
    property p_pd_effect;
        take_pd |=> o_done && o_watchdog_counter_clr && o_clock_off
            && o_power_down_flag && !o_watchdog_timeout_flag;
    endproperty
    a_pd_effect: assert property (p_pd_effect)
        else $error("power-down effect wrong");
    property p_clr_cause;
        o_watchdog_counter_clr |-> $past(take_pd);
    endproperty
    a_clr_cause: assert property (p_clr_cause)
        else $error("counter clear without power-down");
    property p_pdf_sticky;
        o_power_down_flag |=> o_power_down_flag;
    endproperty
    a_pdf_sticky: assert property (p_pdf_sticky)
        else $error("power-down flag lost");
    property p_clock_hold;
        o_clock_off && !i_wake |=> o_clock_off;
    endproperty
    a_clock_hold: assert property (p_clock_hold)
        else $error("clock restarted without wake");
    property p_off_refuse;
        o_clock_off && i_op_valid |=> !o_busy;
    endproperty
    a_off_refuse: assert property (p_off_refuse)
        else $error("operation taken while halted");
    property p_daa_keep;
        take && i_op_code == 3'h1 |=> ##1 $stable(o_zero_flag)
            && $stable(o_half_carry_flag) && $stable(o_working_register);
    endproperty
    a_daa_keep: assert property (p_daa_keep)
        else $error("decimal adjust changed a kept value");
    property p_zero;
        take && i_op_code inside {3'h0, 3'h3, 3'h5} |=> ##1
            o_zero_flag == (o_working_register == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");
    property p_pd_keep;
        take_pd && !i_wreg_load && !i_flag_load |=>
            $stable(o_working_register) && $stable(o_carry_flag);
    endproperty
    a_pd_keep: assert property (p_pd_keep)
        else $error("power-down changed registers");
    property p_off_keep;
        o_clock_off |=> $stable(o_working_register) && $stable(o_zero_flag)
            && $stable(o_carry_flag) && $stable(o_half_carry_flag);
    endproperty
    a_off_keep: assert property (p_off_keep)
        else $error("registers changed while halted");
endmodule
bind bcx_core bcx_core_properties #(.AW(AW)) bcx_core_properties_inst (
    .i_clk_sys, .i_srst, .i_op_valid, .i_op_code, .i_addr, .i_mem_wr,
    .i_mem_wdata, .i_wreg_load, .i_wreg_data, .i_flag_load, .i_flag_zero,
    .i_flag_carry, .i_flag_hcarry, .i_wdt_timeout, .i_wake, .o_busy,
    .o_done, .o_working_register, .o_zero_flag, .o_carry_flag,
    .o_half_carry_flag, .o_power_down_flag, .o_watchdog_timeout_flag,
    .o_watchdog_counter_clr, .o_clock_off
);

// [tb/tb_bcx_core.sv]
// Self-checking bench for the single-operand execution block
`timescale 1ns/1ps
module tb_bcx_core;
    logic       i_clk_sys = 1'b0, i_srst = 1'b1, i_op_valid = 1'b0;
    logic [2:0] i_op_code = 3'h0;
    logic [6:0] i_addr = 7'h00;
    logic       i_mem_wr = 1'b0, i_wreg_load = 1'b0, i_flag_load = 1'b0;
    logic [7:0] i_mem_wdata = 8'h00, i_wreg_data = 8'h00;
    logic       i_flag_zero = 1'b0, i_flag_carry = 1'b0;
    logic       i_flag_hcarry = 1'b0, i_wdt_timeout = 1'b0, i_wake = 1'b0;
    logic       o_busy, o_done, o_zero_flag, o_carry_flag, o_half_carry_flag;
    logic       o_power_down_flag, o_watchdog_timeout_flag;
    logic       o_watchdog_counter_clr, o_clock_off;
    logic [7:0] o_working_register, wr_m;
    logic [7:0] mem_m [128];
    logic [4:0] fl_m;
    int         n_fail = 0;
    int         n_compared = 0;
    bcx_core bcx_core_inst (
        .i_clk_sys, .i_srst, .i_op_valid, .i_op_code, .i_addr, .i_mem_wr,
        .i_mem_wdata, .i_wreg_load, .i_wreg_data, .i_flag_load, .i_flag_zero,
        .i_flag_carry, .i_flag_hcarry, .i_wdt_timeout, .i_wake, .o_busy,
        .o_done, .o_working_register, .o_zero_flag, .o_carry_flag,
        .o_half_carry_flag, .o_power_down_flag, .o_watchdog_timeout_flag,
        .o_watchdog_counter_clr, .o_clock_off
    );
    always #5 i_clk_sys = ~i_clk_sys;
    function automatic logic [7:0] flags();
        return {3'h0, o_power_down_flag, o_watchdog_timeout_flag,
                o_half_carry_flag, o_carry_flag, o_zero_flag};
    endfunction
    // Expected carry and adjusted byte
    function automatic logic [8:0] daa_exp(input logic [7:0] v,
                                           input logic h, input logic c);
        logic [7:0] f;
        logic [8:0] s;
        f = 8'h00;
        if (v[3:0] > 4'h9 || h) f[3:0] = 4'h6;
        if (v[7:4] > 4'h9 || c) f[7:4] = 4'h6;
        s = {1'b0, v} + {1'b0, f};
        return {s[8] | c | f[6], s[7:0]};
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic prep(input logic [6:0] a, input logic [7:0] d,
                        input logic [7:0] w, input logic [2:0] f);
        @(negedge i_clk_sys);
        {i_mem_wr, i_wreg_load, i_flag_load} = 3'b111;
        {i_addr, i_mem_wdata, i_wreg_data} = {a, d, w};
        {i_flag_hcarry, i_flag_carry, i_flag_zero} = f;
        mem_m[a] = d;
        wr_m = w;
        fl_m[2:0] = f;
        @(negedge i_clk_sys);
        {i_mem_wr, i_wreg_load, i_flag_load} = 3'b000;
    endtask
    task automatic run(input logic [2:0] c, input logic [6:0] a);
        logic [8:0] d;
        d = daa_exp(wr_m, fl_m[2], fl_m[1]);
        case (c)
            3'h0: wr_m = ~mem_m[a];
            3'h1: {fl_m[1], mem_m[a]} = d;
            3'h2: mem_m[a] = mem_m[a] - 8'h01;
            3'h3: wr_m = mem_m[a] - 8'h01;
            3'h4: mem_m[a] = mem_m[a] + 8'h01;
            3'h5: wr_m = mem_m[a] + 8'h01;
            default: fl_m[4:3] = 2'b10;
        endcase
        if (c inside {3'h2, 3'h4}) fl_m[0] = (mem_m[a] == 8'h00);
        if (c inside {3'h0, 3'h3, 3'h5}) fl_m[0] = (wr_m == 8'h00);
        repeat (2) @(negedge i_clk_sys);
        {i_op_valid, i_op_code, i_addr} = {1'b1, c, a};
        @(negedge i_clk_sys);
        i_op_valid = 1'b0;
        repeat (4) if (o_done !== 1'b1) @(negedge i_clk_sys);
        chk({7'h00, o_done}, 8'h01);
        chk(o_working_register, wr_m);
        chk(flags(), {3'h0, fl_m});
    endtask
    initial begin
        logic [7:0] d;
        logic [7:0] w;
        logic [2:0] c;
        logic [6:0] a;
        void'($urandom(83101));
        repeat (6) @(negedge i_clk_sys);
        i_srst = 1'b0;
        fl_m = 5'h00;
        chk(flags(), 8'h00);
        for (int i = 0; i < 60; i++) begin
            a = 7'($urandom);
            d = (i < 12) ? ({8{i[0]}} ^ {7'h00, i[1]}) : 8'($urandom);
            w = 8'($urandom);
            if (w[7:4] == 4'h9) w[3] = 1'b0;
            c = (i < 12) ? 3'(i % 6) : 3'($urandom % 6);
            prep(a, d, w, 3'($urandom) & {w[7:4] != 4'h9, 2'b11});
            run(c, a);
            run(3'h0, a);
        end
        @(negedge i_clk_sys);
        i_wdt_timeout = 1'b1;
        @(negedge i_clk_sys);
        i_wdt_timeout = 1'b0;
        fl_m[3] = 1'b1;
        chk(flags(), {3'h0, fl_m});
        run(3'h6, a);
        chk({6'h00, o_watchdog_counter_clr, o_clock_off}, 8'h03);
        {i_op_valid, i_op_code, i_mem_wr} = {1'b1, 3'h4, 1'b1};
        {i_wreg_load, i_flag_load} = 2'b11;
        {i_flag_hcarry, i_flag_carry, i_flag_zero} = ~fl_m[2:0];
        i_wreg_data = ~wr_m;
        i_mem_wdata = ~mem_m[a];
        repeat (3) @(negedge i_clk_sys);
        chk({7'h00, o_busy}, 8'h00);
        chk(o_working_register, wr_m);
        chk(flags(), {3'h0, fl_m});
        {i_op_valid, i_mem_wr, i_wreg_load, i_flag_load, i_wake} = 5'h01;
        @(negedge i_clk_sys);
        i_wake = 1'b0;
        run(3'h0, a);
        complete_run();
    end
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
endmodule
